// File: rtl/dsbb_regs.svh
// Constants for the debug service bus bridge.
`ifndef DSBB_REGS_SVH
`define DSBB_REGS_SVH
`define DSBB_ADDR_W      36
`define DSBB_SLV_MSB     35
`define DSBB_SLV_LSB     32
`define DSBB_SLV_OCD     4'h1
`define DSBB_SLV_HSB     4'h4
`define DSBB_SLV_HSB_ALT 4'h5
`define DSBB_SLV_MSU     4'h6
`define DSBB_SIZE_BYTE   2'h0
`define DSBB_SIZE_HALF   2'h1
`define DSBB_SIZE_WORD   2'h2
`define DSBB_CLK_WAKE_CNT 4'h3
`endif

// File: rtl/dsbb_pkg.sv
// Types of the debug service bus bridge.
`default_nettype none
package dsbb_pkg;
  typedef enum logic [3:0] {
    DSBB_IDLE = 4'h1,
    DSBB_WAKE = 4'h2,
    DSBB_BUS  = 4'h4,
    DSBB_DONE = 4'h8
  } dsbb_state_e;
  typedef logic [3:0] dsbb_slave_t;
endpackage
`default_nettype wire

// File: rtl/dsbb_sync.sv
// Two flip-flop synchroniser for a level crossing into the system clock.
`default_nettype none
module dsbb_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Level
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: rtl/dsbb_bridge.sv
// Bus master bridge from the debug ports onto the service access bus.
`include "dsbb_regs.svh"
`default_nettype none
module dsbb_bridge (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Debugger request, held by the probe logic until acknowledged
  input  wire logic        dbg_clk,
  input  wire logic        jtag_req,
  input  wire logic        swire_req,
  input  wire logic [35:0] dbg_addr,
  input  wire logic [1:0]  dbg_size,
  input  wire logic        dbg_write,
  input  wire logic [31:0] dbg_wdata,
  output logic             dbg_ack,
  output logic             dbg_err,
  output logic [31:0]      dbg_rdata,
  output logic [15:0]      clk_ratio,
  // System clock control
  input  wire logic        sys_clk_running,
  output logic             sys_clk_wake_req,
  // Service access bus master
  output logic             sab_valid,
  output logic [3:0]       sab_slave,
  output logic [31:0]      sab_addr,
  output logic [1:0]       sab_size,
  output logic             sab_write,
  output logic [31:0]      sab_wdata,
  output logic             sab_sel_ocd,
  output logic             sab_sel_hsb,
  output logic             sab_sel_msu,
  input  wire logic        sab_ready,
  input  wire logic [31:0] sab_rdata
);
  logic                 jreq_s;
  logic                 sreq_s;
  logic                 dclk_s;
  logic                 dclk_prev_q;
  dsbb_pkg::dsbb_state_e state_q;
  dsbb_pkg::dsbb_state_e state_d;
  logic [35:0]          addr_q;
  logic [1:0]           size_q;
  logic                 write_q;
  logic [31:0]          wdata_q;
  logic                 err_q;
  logic [31:0]          rdata_q;
  logic [15:0]          ratio_cnt_q;
  logic [15:0]          ratio_q;
  logic [3:0]           wait_q;

  // Requests and the debugger clock cross in as levels.
  dsbb_sync u_sync_j (.clk(clk), .resetn(resetn), .async_in(jtag_req), .sync_out(jreq_s));
  dsbb_sync u_sync_s (.clk(clk), .resetn(resetn), .async_in(swire_req), .sync_out(sreq_s));
  dsbb_sync u_sync_c (.clk(clk), .resetn(resetn), .async_in(dbg_clk), .sync_out(dclk_s));

  // Address, size and data are stable while the request is high, so sampling them after
  // the synchronised request is safe.
  wire                  req_any   = jreq_s | sreq_s;
  wire                  dclk_rise = dclk_s & ~dclk_prev_q;
  wire dsbb_pkg::dsbb_slave_t slv = addr_q[`DSBB_SLV_MSB:`DSBB_SLV_LSB];
  wire                  hit_ocd   = (slv == `DSBB_SLV_OCD);
  wire                  hit_hsb   = (slv == `DSBB_SLV_HSB) | (slv == `DSBB_SLV_HSB_ALT);
  wire                  hit_msu   = (slv == `DSBB_SLV_MSU);
  wire                  mapped    = hit_ocd | hit_hsb | hit_msu;
  wire                  misalign  = ((size_q == `DSBB_SIZE_HALF) & addr_q[0]) |
                                    ((size_q == `DSBB_SIZE_WORD) & (addr_q[1:0] != 2'h0)) |
                                    (size_q == 2'h3);
  wire                  bad       = ~mapped | misalign;
  wire                  in_bus    = (state_q == dsbb_pkg::DSBB_BUS);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dsbb_pkg::DSBB_IDLE: if (req_any) state_d = dsbb_pkg::DSBB_WAKE;
      dsbb_pkg::DSBB_WAKE: begin
        if (bad) begin
          state_d = dsbb_pkg::DSBB_DONE;
        end else if (sys_clk_running && wait_q == `DSBB_CLK_WAKE_CNT) begin
          state_d = dsbb_pkg::DSBB_BUS;
        end
      end
      dsbb_pkg::DSBB_BUS:  if (sab_ready) state_d = dsbb_pkg::DSBB_DONE;
      dsbb_pkg::DSBB_DONE: if (!req_any) state_d = dsbb_pkg::DSBB_IDLE;
      default:             state_d = dsbb_pkg::DSBB_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= dsbb_pkg::DSBB_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      addr_q  <= 36'h0_0000_0000;
      size_q  <= 2'h0;
      write_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
    end else if (state_q == dsbb_pkg::DSBB_IDLE && req_any) begin
      addr_q  <= dbg_addr;
      size_q  <= dbg_size;
      write_q <= dbg_write;
      wdata_q <= dbg_wdata;
    end
  end

  // Hold off the bus until the system clock reports running for a few cycles.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wait_q <= 4'h0;
    end else if (state_q != dsbb_pkg::DSBB_WAKE || !sys_clk_running) begin
      wait_q <= 4'h0;
    end else if (wait_q != `DSBB_CLK_WAKE_CNT) begin
      wait_q <= wait_q + 4'h1;
    end
  end

  // Byte and halfword reads return zero in the unused upper lanes.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      err_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else if (state_q == dsbb_pkg::DSBB_WAKE && bad) begin
      err_q   <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (in_bus && sab_ready) begin
      err_q <= 1'b0;
      unique case (size_q)
        `DSBB_SIZE_BYTE: rdata_q <= {24'h00_0000, sab_rdata[7:0]};
        `DSBB_SIZE_HALF: rdata_q <= {16'h0000, sab_rdata[15:0]};
        default:         rdata_q <= sab_rdata;
      endcase
    end
  end

  // System clock cycles per debugger clock period, for rate tuning by the probe.
  // The edge detector is reset to the idle level of the probe clock, so no false edge follows reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dclk_prev_q <= 1'b0;
      ratio_cnt_q <= 16'h0000;
      ratio_q     <= 16'h0000;
    end else begin
      dclk_prev_q <= dclk_s;
      if (dclk_rise) begin
        ratio_q     <= ratio_cnt_q;
        ratio_cnt_q <= 16'h0001;
      end else if (ratio_cnt_q != 16'hFFFF) begin
        ratio_cnt_q <= ratio_cnt_q + 16'h0001;
      end
    end
  end

  // The wake request goes only to the clock generator, never to the processor.
  assign sys_clk_wake_req = (state_q != dsbb_pkg::DSBB_IDLE) | req_any;
  assign sab_valid        = in_bus;
  assign sab_slave        = slv;
  assign sab_addr         = addr_q[31:0];
  assign sab_size         = size_q;
  assign sab_write        = write_q;
  assign sab_wdata        = wdata_q;
  assign sab_sel_ocd      = in_bus & hit_ocd;
  assign sab_sel_hsb      = in_bus & hit_hsb;
  assign sab_sel_msu      = in_bus & hit_msu;
  assign dbg_ack          = (state_q == dsbb_pkg::DSBB_DONE);
  assign dbg_err          = err_q;
  assign dbg_rdata        = rdata_q;
  assign clk_ratio        = ratio_q;

  // The checks below watch the bus side and the probe-side acknowledge, error and read data; the bench also judges each access.
  a_no_bad_access: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid |-> mapped && !misalign) else $error("bad access on service bus");
  a_bus_needs_clk: assert property (@(posedge clk) disable iff (!resetn)
    $rose(sab_valid) |-> $past(sys_clk_running, 1) && $past(sys_clk_running, 4)) else $error("bus without clock");
  a_hsb_decode: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid && (sab_slave == 4'h4 || sab_slave == 4'h5) |-> sab_sel_hsb && !sab_sel_ocd) else $error("hsb decode");
  a_ocd_decode: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid && sab_slave == 4'h1 |-> sab_sel_ocd && !sab_sel_msu) else $error("ocd decode");
  a_msu_decode: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid && sab_slave == 4'h6 |-> sab_sel_msu && !sab_sel_hsb) else $error("msu decode");
  a_addr_low: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid |-> sab_addr == addr_q[31:0] && $stable(sab_addr)) else $error("address unstable");
  a_err_ack: assert property (@(posedge clk) disable iff (!resetn)
    state_q == dsbb_pkg::DSBB_WAKE && bad |=> dbg_ack && dbg_err && !sab_valid) else $error("error not reported");
  a_wake_req: assert property (@(posedge clk) disable iff (!resetn)
    req_any |-> sys_clk_wake_req) else $error("no clock wake");
  a_byte_read: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid && sab_ready && sab_size == 2'h0 |=> dbg_rdata[31:8] == 24'h00_0000) else $error("byte width");
  a_data_sync: assert property (@(posedge clk) disable iff (!resetn)
    $rose(req_any) && state_q == dsbb_pkg::DSBB_IDLE |=> !sab_valid) else $error("bus before sync");
  // A slave that inserts wait states relies on the request standing still until it answers.
  a_bus_hold: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid && !sab_ready |=> sab_valid && $stable(sab_addr) && $stable(sab_slave) && $stable(sab_wdata))
    else $error("bus request changed before ready");
  a_half_read: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid && sab_ready && sab_size == 2'h1 |=> dbg_rdata[31:16] == 16'h0000) else $error("halfword width");
  a_ack_after_bus: assert property (@(posedge clk) disable iff (!resetn)
    sab_valid && sab_ready |=> dbg_ack && !dbg_err && !sab_valid) else $error("good access not acknowledged");
  a_ack_holds: assert property (@(posedge clk) disable iff (!resetn)
    dbg_ack && req_any |=> dbg_ack) else $error("acknowledge dropped under request");
  // With the system clock stopped a mapped, aligned access waits in place rather than reaching the bus.
  a_no_bus_stopped: assert property (@(posedge clk) disable iff (!resetn)
    state_q == dsbb_pkg::DSBB_WAKE && !sys_clk_running |=> !sab_valid) else $error("bus with clock stopped");
  c_hsb_access: cover property (@(posedge clk) sab_valid && sab_ready && sab_sel_hsb);
  c_ocd_write: cover property (@(posedge clk) sab_valid && sab_write && sab_sel_ocd);
  c_error: cover property (@(posedge clk) dbg_ack && dbg_err);
  c_ratio: cover property (@(posedge clk) dclk_rise && ratio_cnt_q > 16'h0004);
  c_wake_wait: cover property (@(posedge clk) state_q == dsbb_pkg::DSBB_WAKE && !sys_clk_running);
endmodule
`default_nettype wire

// File: tb/dsbb_slave_model.sv
// Service bus slave model answering after a set number of wait cycles.
`default_nettype none
module dsbb_slave_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Service bus
  input  wire logic        sab_valid,
  input  wire logic [31:0] sab_addr,
  input  wire logic [1:0]  sab_size,
  input  wire logic [3:0]  dly,
  output logic             sab_ready,
  output logic [31:0]      sab_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  cnt_q;
  logic [31:0] word;
  assign word = sab_addr ^ 32'hA5C3_9E17;
  assign sab_ready = sab_valid && (cnt_q == dly);
  // Lanes outside the size and idle cycles carry junk, so a bridge that keeps them is caught.
  assign sab_rdata = !sab_ready ? ~word ^ {28'h0, cnt_q} :
                     sab_size == 2'h0 ? {~word[31:8], word[7:0]} :
                     sab_size == 2'h1 ? {~word[31:16], word[15:0]} : word;
  always_ff @(posedge clk) begin
    if (!resetn || !sab_valid || sab_ready) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench for the debug service bus bridge.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, resetn = 1'b0, dbg_clk = 1'b0, run = 1'b1;
  logic        jtag_req = 1'b0, swire_req = 1'b0, dbg_write = 1'b0;
  logic [35:0] dbg_addr = '0;
  logic [1:0]  dbg_size = '0;
  logic [31:0] dbg_wdata = '0;
  logic [3:0]  dly = 4'h0;
  logic        dbg_ack, dbg_err, wake, sab_valid, sab_write, sel_ocd, sel_hsb, sel_msu, sab_ready;
  logic [31:0] dbg_rdata, sab_addr, sab_wdata, sab_rdata;
  logic [15:0] clk_ratio;
  logic [3:0]  sab_slave;
  logic [1:0]  sab_size;
  int          n_errors = 0, checks_done = 0, cyc = 0;
  always #2.5 clk = ~clk;
  always #32 dbg_clk = ~dbg_clk;
  dsbb_bridge dsbb_bridge_i (.clk(clk), .resetn(resetn), .dbg_clk(dbg_clk), .jtag_req(jtag_req),
    .swire_req(swire_req), .dbg_addr(dbg_addr), .dbg_size(dbg_size), .dbg_write(dbg_write),
    .dbg_wdata(dbg_wdata), .dbg_ack(dbg_ack), .dbg_err(dbg_err), .dbg_rdata(dbg_rdata),
    .clk_ratio(clk_ratio), .sys_clk_running(run), .sys_clk_wake_req(wake), .sab_valid(sab_valid),
    .sab_slave(sab_slave), .sab_addr(sab_addr), .sab_size(sab_size), .sab_write(sab_write),
    .sab_wdata(sab_wdata), .sab_sel_ocd(sel_ocd), .sab_sel_hsb(sel_hsb), .sab_sel_msu(sel_msu),
    .sab_ready(sab_ready), .sab_rdata(sab_rdata));
  dsbb_slave_model dsbb_slave_model_i (.clk(clk), .resetn(resetn), .sab_valid(sab_valid),
    .sab_addr(sab_addr), .sab_size(sab_size), .dly(dly), .sab_ready(sab_ready), .sab_rdata(sab_rdata));
  task automatic end_of_test();
    $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One access; the request is held until acknowledged, then dropped until the answer clears.
  task automatic acc(input logic [35:0] a, input logic [1:0] sz, input logic sw, input logic bad);
    int n;
    logic seen;
    logic [31:0] e;
    seen = 1'b0;
    e = a[31:0] ^ 32'hA5C3_9E17;
    e = sz == 2'h0 ? {24'h0, e[7:0]} : sz == 2'h1 ? {16'h0, e[15:0]} : e;
    dbg_addr = a;
    dbg_size = sz;
    dbg_write = a[3];
    dbg_wdata = ~a[31:0];
    jtag_req = !sw;
    swire_req = sw;
    n = 0;
    while (dbg_ack !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
      if (sab_valid === 1'b1) begin
        seen = 1'b1;
        chk({sab_slave, sab_size, sab_write}, {a[35:32], sz, a[3]});
        chk({sel_ocd, sel_hsb, sel_msu}, {a[35:32] == 4'h1, a[35:33] == 3'h2, a[35:32] == 4'h6});
        chk(sab_addr, a[31:0]);
        if (a[3]) chk(sab_wdata, ~a[31:0]);
      end
    end
    chk({dbg_ack, seen, dbg_err}, {1'b1, !bad, bad});
    if (!bad && !a[3]) chk(dbg_rdata, e);
    jtag_req = 1'b0;
    swire_req = 1'b0;
    n = 0;
    while (dbg_ack !== 1'b0 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(dbg_ack, 1'b0);
  endtask
  task automatic t_map();
    for (int s = 0; s < 16; s++) begin
      acc({s[3:0], 32'h1357_9BD0 | {28'h0, s[0], 3'h0}}, 2'h2, s[1], !(s inside {1, 4, 5, 6}));
    end
  endtask
  task automatic t_size();
    logic [3:0] off [6] = '{4'h3, 4'h2, 4'hC, 4'h1, 4'h6, 4'h0};
    logic [1:0] sz [6] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h2, 2'h3};
    dly = 4'h3;
    for (int i = 0; i < 6; i++) begin
      acc({4'h5, 28'h2468_ACE, off[i]}, sz[i], i[0], i > 2);
    end
    dly = 4'h0;
  endtask
  task automatic t_wake();
    run = 1'b0;
    dbg_addr = {4'h4, 32'h0000_0040};
    dbg_size = 2'h2;
    dbg_write = 1'b0;
    dbg_wdata = 32'hFFFF_FFBF;
    jtag_req = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk({sab_valid, dbg_ack, wake}, 3'h1);
    chk(wake, 1'b1);
    run = 1'b1;
    acc({4'h4, 32'h0000_0040}, 2'h2, 1'b0, 1'b0);
  endtask
  task automatic t_ratio();
    repeat (60) @(posedge clk);
    #1;
    chk(clk_ratio inside {16'h000C, 16'h000D}, 1'b1);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1;
    chk({dbg_ack, dbg_err, sab_valid, wake, clk_ratio}, 20'h0_0000);
    resetn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_map();
    t_size();
    t_wake();
    t_ratio();
    end_of_test();
  end
endmodule
`default_nettype wire
